// >>> src/power_result_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "power_result_map.svh"
module power_result_bank
  import power_result_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic meas_valid_i,
  input wire meas_type meas_i,
  input wire result_cfg_type cfg_i,
  input wire reg_req_type reg_req_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic avg_short_update_o,
  output logic avg_long_update_o
);

  ////////////////////////////////////////////////////////////////////////////
  // word formatting helpers

  // unsigned value into the low bits, everything above reads zero
  function automatic logic [31:0] place_low17(input logic [16:0] v);
    logic [31:0] w;
    w = `RST_WORD;
    w[`FLD_LOW_LSB +: 17] = v;
    return w;
  endfunction

  // signed value kept at its own width; upper bits zero, not sign-extended
  function automatic logic [31:0] place_signed17(input logic signed [16:0] v);
    logic [31:0] w;
    w = `RST_WORD;
    w[`FLD_LOW_LSB +: 17] = v;
    return w;
  endfunction

  // sixteen-bit apparent power into the low half
  function automatic logic [31:0] place_low16(input logic [15:0] v);
    logic [31:0] w;
    w = `RST_WORD;
    w[`FLD_LOW_LSB +: 16] = v;
    return w;
  endfunction

  // nine-bit count or fraction; bits above, 10:9 included, read zero
  function automatic logic [31:0] place_low9(input logic [8:0] v);
    logic [31:0] w;
    w = `RST_WORD;
    w[`FLD_LOW_LSB +: 9] = v;
    return w;
  endfunction

  // two 15-bit rms fields packed into one word
  function automatic logic [31:0] place_rms_pair(input vrms_type v, input irms_type i);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FLD_VRMS_LSB +: 15] = v;
    w[`FLD_IRMS_LSB +: 15] = i;
    return w;
  endfunction

  // averaged voltage is held only while voltage is the selected channel
  function automatic vrms_type keep_voltage(input logic sel_current, input vrms_type v);
    if (sel_current) begin
      return 15'h0000;
    end else begin
      return v; // unsigned, all 15 bits fractional
    end
  endfunction

  // averaged current is held only while current is the selected channel
  function automatic irms_type keep_current(input logic sel_current, input irms_type i);
    if (sel_current) begin
      return i; // unsigned, 14 fractional bits
    end else begin
      return 15'h0000;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // latched instantaneous-window results

  papparent_type papparent_reg, papparent_next;
  preactive_type preactive_reg, preactive_next;
  pfactor_type pfactor_reg, pfactor_next;
  sample_count_type count_dyn_reg, count_dyn_next;
  vsample_type vsample_reg, vsample_next;
  isample_type isample_reg, isample_next;

  // capture a full set so a read never mixes two update periods
  always_comb begin
    papparent_next = papparent_reg;
    preactive_next = preactive_reg;
    pfactor_next = pfactor_reg;
    count_dyn_next = count_dyn_reg;
    vsample_next = vsample_reg;
    isample_next = isample_reg;
    if (meas_valid_i) begin
      papparent_next = meas_i.papparent;
      preactive_next = meas_i.preactive;
      pfactor_next = meas_i.pfactor;
      count_dyn_next = meas_i.count_dynamic;
      vsample_next = meas_i.vsample;
      isample_next = meas_i.isample;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      papparent_reg <= '0;
      preactive_reg <= '0;
      pfactor_reg <= '0;
      count_dyn_reg <= '0;
      vsample_reg <= '0;
      isample_reg <= '0;
    end else begin
      papparent_reg <= papparent_next;
      preactive_reg <= preactive_next;
      pfactor_reg <= pfactor_next;
      count_dyn_reg <= count_dyn_next;
      vsample_reg <= vsample_next;
      isample_reg <= isample_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // averaging chains

  logic [14:0] rms_pick;
  logic [14:0] rms_avg_short;
  logic [14:0] rms_avg_long;
  logic rms_short_valid;
  logic rms_long_valid;
  logic [16:0] pact_avg_short;
  logic [16:0] pact_avg_long;
  logic pact_short_valid;
  logic pact_long_valid;

  // only one rms channel is averaged at a time; select steers which
  assign rms_pick = cfg_i.avg_select_current ? meas_i.irms : meas_i.vrms;

  // short window fed straight from the measurement updates
  window_averager #(
    .WIDTH(15),
    .SIGNED_DATA(1'b0)
  ) u_rms_short (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sample_valid_i(meas_valid_i),
    .sample_i(rms_pick),
    .shift_i(cfg_i.avg_short_shift),
    .average_o(rms_avg_short),
    .average_valid_o(rms_short_valid)
  );

  // long window averages short results, so it can stretch to minutes
  window_averager #(
    .WIDTH(15),
    .SIGNED_DATA(1'b0)
  ) u_rms_long (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sample_valid_i(rms_short_valid),
    .sample_i(rms_avg_short),
    .shift_i(cfg_i.avg_long_shift),
    .average_o(rms_avg_long),
    .average_valid_o(rms_long_valid)
  );

  window_averager #(
    .WIDTH(17),
    .SIGNED_DATA(1'b1)
  ) u_pact_short (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sample_valid_i(meas_valid_i),
    .sample_i(meas_i.pactive),
    .shift_i(cfg_i.avg_short_shift),
    .average_o(pact_avg_short),
    .average_valid_o(pact_short_valid)
  );

  window_averager #(
    .WIDTH(17),
    .SIGNED_DATA(1'b1)
  ) u_pact_long (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .sample_valid_i(pact_short_valid),
    .sample_i(pact_avg_short),
    .shift_i(cfg_i.avg_long_shift),
    .average_o(pact_avg_long),
    .average_valid_o(pact_long_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // averaged result holding

  vrms_type vavg_short_reg, vavg_short_next;
  irms_type iavg_short_reg, iavg_short_next;
  vrms_type vavg_long_reg, vavg_long_next;
  irms_type iavg_long_reg, iavg_long_next;
  pactive_type pavg_short_reg, pavg_short_next;
  pactive_type pavg_long_reg, pavg_long_next;
  logic short_update_reg, short_update_next;
  logic long_update_reg, long_update_next;

  // the unselected channel is forced to zero at capture time
  always_comb begin
    vavg_short_next = vavg_short_reg;
    iavg_short_next = iavg_short_reg;
    vavg_long_next = vavg_long_reg;
    iavg_long_next = iavg_long_reg;
    pavg_short_next = pavg_short_reg;
    pavg_long_next = pavg_long_reg;
    short_update_next = rms_short_valid | pact_short_valid;
    long_update_next = rms_long_valid | pact_long_valid;
    if (rms_short_valid) begin
      vavg_short_next = keep_voltage(cfg_i.avg_select_current, rms_avg_short);
      iavg_short_next = keep_current(cfg_i.avg_select_current, rms_avg_short);
    end
    if (rms_long_valid) begin
      vavg_long_next = keep_voltage(cfg_i.avg_select_current, rms_avg_long);
      iavg_long_next = keep_current(cfg_i.avg_select_current, rms_avg_long);
    end
    if (pact_short_valid) begin
      pavg_short_next = pact_avg_short;
    end
    if (pact_long_valid) begin
      pavg_long_next = pact_avg_long;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      vavg_short_reg <= '0;
      iavg_short_reg <= '0;
      vavg_long_reg <= '0;
      iavg_long_reg <= '0;
      pavg_short_reg <= '0;
      pavg_long_reg <= '0;
      short_update_reg <= 1'b0;
      long_update_reg <= 1'b0;
    end else begin
      vavg_short_reg <= vavg_short_next;
      iavg_short_reg <= iavg_short_next;
      vavg_long_reg <= vavg_long_next;
      iavg_long_reg <= iavg_long_next;
      pavg_short_reg <= pavg_short_next;
      pavg_long_reg <= pavg_long_next;
      short_update_reg <= short_update_next;
      long_update_reg <= long_update_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] word_pick;

  // select also masks at read time, so a select change hides stale data
  always_comb begin
    word_pick = `RST_WORD;
    unique case (reg_req_i.addr)
      `OFS_APPARENT_POWER: begin
        word_pick = place_low16(papparent_reg);
      end
      `OFS_REACTIVE_POWER: begin
        word_pick = place_low17(preactive_reg);
      end
      `OFS_POWER_FACTOR: begin
        word_pick = place_low9(pfactor_reg); // bits 10:9 stay zero
      end
      `OFS_SAMPLE_COUNT: begin
        if (cfg_i.bypass_count) begin
          word_pick = place_low9(cfg_i.fixed_count);
        end else begin
          word_pick = place_low9(count_dyn_reg);
        end
      end
      `OFS_RMS_AVG_SHORT: begin
        word_pick = place_rms_pair(
          keep_voltage(cfg_i.avg_select_current, vavg_short_reg),
          keep_current(cfg_i.avg_select_current, iavg_short_reg));
      end
      `OFS_RMS_AVG_LONG: begin
        word_pick = place_rms_pair(
          keep_voltage(cfg_i.avg_select_current, vavg_long_reg),
          keep_current(cfg_i.avg_select_current, iavg_long_reg));
      end
      `OFS_PACT_AVG_SHORT: begin
        word_pick = place_signed17(pavg_short_reg);
      end
      `OFS_PACT_AVG_LONG: begin
        word_pick = place_signed17(pavg_long_reg);
      end
      `OFS_INSTANT_VOLTAGE: begin
        word_pick = place_signed17(vsample_reg);
      end
      `OFS_INSTANT_CURRENT: begin
        word_pick = place_signed17(isample_reg);
      end
      default: begin
        word_pick = `RST_WORD; // other offsets belong elsewhere; answer zero
      end
    endcase
  end

  // reads answer one cycle later; writes change nothing here
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_req_i.rd) begin
      rdata_next = word_pick;
      rvalid_next = 1'b1;
    end
    // reg_req_i.wr and wdata deliberately unused: bank is read-only
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_reg <= `RST_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign avg_short_update_o = short_update_reg;
  assign avg_long_update_o = long_update_reg;

endmodule
`default_nettype wire

// >>> src/power_result_map.svh
// Overview of operation
// - apparent power: unsigned 16 bits, 15 fractional, in bits 15:0.
// - reactive power: unsigned 17 bits, 16 fractional, in bits 16:0.
// - power factor: unsigned 9-bit pure fraction inside field 10:0.
// - bypass clear: bits 8:0 report dynamic zero-crossing sample count, 0 to 511.
// - bypass set: reported sample count equals the preset fixed count.
// - short-window averaged vrms in bits 14:0, irms in 30:16.
// - long-window averaged vrms in bits 14:0, irms in 30:16, separate word.
// - averaging select 1: both averaged voltage fields read zero.
// - averaging select 0: both averaged current fields read zero.
// - short-window averaged active power in bits 16:0.
// - long-window averaged active power in bits 16:0.
// - raw voltage sample: signed 17 bits, 16 fractional, bits 16:0.
// - raw current sample: signed 17 bits, 15 fractional, bits 16:0.
// - averaged active power: signed 17 bits, 15 fractional.
// - voltage rms values: unsigned 15-bit fraction, all bits fractional.
// - current rms values: unsigned 15 bits, 14 fractional.
`ifndef POWER_RESULT_MAP_SVH
`define POWER_RESULT_MAP_SVH

// register offsets
`define OFS_APPARENT_POWER 8'h22
`define OFS_REACTIVE_POWER 8'h23
`define OFS_POWER_FACTOR 8'h24
`define OFS_SAMPLE_COUNT 8'h25
`define OFS_RMS_AVG_SHORT 8'h26
`define OFS_RMS_AVG_LONG 8'h27
`define OFS_PACT_AVG_SHORT 8'h28
`define OFS_PACT_AVG_LONG 8'h29
`define OFS_INSTANT_VOLTAGE 8'h2a
`define OFS_INSTANT_CURRENT 8'h2b

// field positions
`define FLD_VRMS_LSB 0
`define FLD_IRMS_LSB 16
`define FLD_LOW_LSB 0

// reset values
`define RST_WORD 32'h0000_0000
`define RST_SHIFT 4'h0

`endif

// >>> src/power_result_pkg.sv
package power_result_pkg;

  typedef logic [14:0] vrms_type;
  typedef logic [14:0] irms_type;
  typedef logic signed [16:0] pactive_type;
  typedef logic [15:0] papparent_type;
  typedef logic [16:0] preactive_type;
  typedef logic [8:0] pfactor_type;
  typedef logic [8:0] sample_count_type;
  typedef logic signed [16:0] vsample_type;
  typedef logic signed [16:0] isample_type;

  // one set of results from the measurement engine
  typedef struct packed {
    vrms_type vrms;
    irms_type irms;
    pactive_type pactive;
    papparent_type papparent;
    preactive_type preactive;
    pfactor_type pfactor;
    sample_count_type count_dynamic;
    vsample_type vsample;
    isample_type isample;
  } meas_type;

  // configuration that steers the bank
  typedef struct packed {
    logic bypass_count;
    sample_count_type fixed_count;
    logic avg_select_current;
    logic [3:0] avg_short_shift;
    logic [3:0] avg_long_shift;
  } result_cfg_type;

  // register read or write request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage

// >>> src/window_averager.sv
`timescale 1ns/1ps
`default_nettype none
module window_averager #(
  parameter int WIDTH = 17,
  parameter bit SIGNED_DATA = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sample_valid_i,
  input wire logic [WIDTH-1:0] sample_i,
  input wire logic [3:0] shift_i,
  output logic [WIDTH-1:0] average_o,
  output logic average_valid_o
);

  localparam int ACC_W = WIDTH + 16;

  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [15:0] count_reg, count_next;
  logic [WIDTH-1:0] average_reg, average_next;
  logic average_valid_reg, average_valid_next;

  // extend a sample to accumulator width, honouring its sign
  function automatic logic [ACC_W-1:0] extend(input logic [WIDTH-1:0] v);
    if (SIGNED_DATA) begin
      return {{16{v[WIDTH-1]}}, v};
    end else begin
      return {16'h0000, v};
    end
  endfunction

  // window of 2**shift samples; power of two trades window choice for no divider
  always_comb begin
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] scaled;
    sum = acc_reg + extend(sample_i);
    scaled = '0;
    acc_next = acc_reg;
    count_next = count_reg;
    average_next = average_reg;
    average_valid_next = 1'b0;
    if (sample_valid_i) begin
      if (count_reg >= ((16'h0001 << shift_i) - 16'h0001)) begin
        if (SIGNED_DATA) begin
          scaled = ACC_W'($signed(sum) >>> shift_i);
        end else begin
          scaled = sum >> shift_i;
        end
        average_next = scaled[WIDTH-1:0];
        average_valid_next = 1'b1;
        acc_next = '0;
        count_next = 16'h0000;
      end else begin
        acc_next = sum;
        count_next = count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc_reg <= '0;
      count_reg <= 16'h0000;
      average_reg <= '0;
      average_valid_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      count_reg <= count_next;
      average_reg <= average_next;
      average_valid_reg <= average_valid_next;
    end
  end

  assign average_o = average_reg;
  assign average_valid_o = average_valid_reg;

endmodule
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import power_result_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output var reg_req_type req_o
);
  initial req_o = '0;
  // one strobe cycle; answer taken one edge later
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic got);
    @(negedge clk_sys_i);
    req_o.rd = !wr;
    req_o.wr = wr;
    req_o.addr = a;
    req_o.wdata = d;
    @(negedge clk_sys_i);
    got = rvalid_i;
    q = rdata_i;
    req_o.rd = 1'b0;
    req_o.wr = 1'b0;
    // released lines never keep the last value
    req_o.addr = ~a;
    req_o.wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/power_result_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module power_result_bank_asserts
  import power_result_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire result_cfg_type cfg_i,
  input wire reg_req_type reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  // answer timing: one answer per read, writes get none
  property p_answer;
    reg_req_i.rd |=> reg_rvalid_o;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered next cycle");
  property p_no_answer;
    !reg_req_i.rd |=> !reg_rvalid_o;
  endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");
  property p_hold;
    !reg_rvalid_o |-> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  ////////////////////////////////////////////////////////////////////////////////
  // field widths: bits above each field read zero
  property p_apparent;
    reg_req_i.rd && reg_req_i.addr == 8'h22 |=> reg_rdata_o[31:16] == 16'h0;
  endproperty
  a_apparent: assert property (p_apparent) else $error("apparent upper bits set");
  property p_reactive;
    reg_req_i.rd && reg_req_i.addr == 8'h23 |=> reg_rdata_o[31:17] == 15'h0;
  endproperty
  a_reactive: assert property (p_reactive) else $error("reactive upper bits set");
  property p_pfactor;
    reg_req_i.rd && reg_req_i.addr == 8'h24 |=> reg_rdata_o[31:9] == 23'h0;
  endproperty
  a_pfactor: assert property (p_pfactor) else $error("power factor upper bits set");
  property p_samples;
    reg_req_i.rd && reg_req_i.addr inside {8'h2a, 8'h2b} |=> reg_rdata_o[31:17] == 15'h0;
  endproperty
  a_samples: assert property (p_samples) else $error("sample sign-extended");
  ////////////////////////////////////////////////////////////////////////////////
  // count source follows the bypass setting live
  property p_fixed_count;
    reg_req_i.rd && reg_req_i.addr == 8'h25 && cfg_i.bypass_count
      ##1 reg_rvalid_o |-> reg_rdata_o == {23'h0, $past(cfg_i.fixed_count)};
  endproperty
  a_fixed_count: assert property (p_fixed_count) else $error("bypass count wrong");
  property p_dyn_count;
    reg_req_i.rd && reg_req_i.addr == 8'h25 |=> reg_rdata_o[31:9] == 23'h0;
  endproperty
  a_dyn_count: assert property (p_dyn_count) else $error("count upper bits set");
  // unselected averaged channel reads zero
  property p_volt_off;
    reg_req_i.rd && reg_req_i.addr inside {8'h26, 8'h27} && cfg_i.avg_select_current
      |=> reg_rdata_o[15:0] == 16'h0;
  endproperty
  a_volt_off: assert property (p_volt_off) else $error("voltage average not zero");
  property p_curr_off;
    reg_req_i.rd && reg_req_i.addr inside {8'h26, 8'h27} && !cfg_i.avg_select_current
      |=> reg_rdata_o[31:15] == 17'h0;
  endproperty
  a_curr_off: assert property (p_curr_off) else $error("current average not zero");
endmodule
bind power_result_bank power_result_bank_asserts u_chk (
  .clk_sys_i(clk_sys_i),
  .reset_i(reset_i),
  .cfg_i(cfg_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o)
);
`default_nettype wire

// >>> tb/power_result_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_result_bank_tb;
  import power_result_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic meas_valid_i = 1'b0;
  meas_type meas_i = '0;
  result_cfg_type cfg_i = '0;
  reg_req_type reg_req_i;
  logic [31:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic avg_short_update_o;
  logic avg_long_update_o;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  power_result_bank dut (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .meas_valid_i(meas_valid_i),
    .meas_i(meas_i),
    .cfg_i(cfg_i),
    .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .avg_short_update_o(avg_short_update_o),
    .avg_long_update_o(avg_long_update_o)
  );
  host_model host (
    .clk_sys_i(clk_sys_i),
    .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o),
    .req_o(reg_req_i)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    logic got;
    host.access(1'b0, a, 32'h0, q, got);
    chk("rvalid", {31'h0, got}, 32'h1);
    chk(nm, q, exp);
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
  endtask
  // one capture pulse, then a quiet cycle
  task automatic push(logic [14:0] v, pactive_type p);
    @(negedge clk_sys_i);
    meas_i.vrms = v;
    meas_i.irms = v;
    meas_i.pactive = p;
    meas_valid_i = 1'b1;
    @(negedge clk_sys_i);
    meas_valid_i = 1'b0;
  endtask
  task automatic wait_upd(logic long_win);
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys_i);
      if ((long_win ? avg_long_update_o : avg_short_update_o) === 1'b1) begin
        return;
      end
    end
    chk("update pulse", 32'h0, 32'h1);
    end_sim();
  endtask
  function automatic logic [31:0] rms_word(logic s, logic [14:0] x);
    return s ? {1'b0, x, 16'h0} : {17'h0, x};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // every word reads zero out of reset, unmapped too
  task automatic t_reset_values();
    for (int a = 8'h22; a <= 8'h2b; a++) begin
      rd_chk("reset word", a[7:0], 32'h0);
    end
    rd_chk("unmapped", 8'h30, 32'h0);
  endtask
  // negative samples must not be sign-extended
  task automatic t_instant();
    logic [31:0] q;
    logic got;
    meas_i.papparent = 16'h8001;
    meas_i.preactive = 17'h10001;
    meas_i.pfactor = 9'h1ff;
    meas_i.count_dynamic = 9'h0ff;
    meas_i.vsample = 17'h18000;
    meas_i.isample = 17'h10003;
    push(15'h0, 17'h0);
    rd_chk("apparent", 8'h22, 32'h0000_8001);
    rd_chk("reactive", 8'h23, 32'h0001_0001);
    rd_chk("pfactor", 8'h24, 32'h0000_01ff);
    rd_chk("count dyn", 8'h25, 32'h0000_00ff);
    rd_chk("vsample", 8'h2a, 32'h0001_8000);
    rd_chk("isample", 8'h2b, 32'h0001_0003);
    host.access(1'b1, 8'h22, 32'hffff_ffff, q, got);
    chk("write answer", {31'h0, got}, 32'h0);
    rd_chk("after write", 8'h22, 32'h0000_8001);
    cfg_i.fixed_count = 9'h0ab;
    cfg_i.bypass_count = 1'b1;
    rd_chk("count fixed", 8'h25, 32'h0000_00ab);
    cfg_i.bypass_count = 1'b0;
    rd_chk("count back", 8'h25, 32'h0000_00ff);
  endtask
  // two-sample windows: short then long, sel picks the channel
  task automatic t_avg(logic sel);
    cfg_i.avg_select_current = sel;
    cfg_i.avg_short_shift = 4'h1;
    cfg_i.avg_long_shift = 4'h1;
    do_reset();
    push(15'h0100, 17'h1fffd);
    push(15'h0103, 17'h1fffc);
    wait_upd(1'b0);
    rd_chk("rms short", 8'h26, rms_word(sel, 15'h0101));
    rd_chk("pact short", 8'h28, 32'h0001_fffc);
    push(15'h0200, 17'h00002);
    push(15'h0202, 17'h00004);
    wait_upd(1'b1);
    rd_chk("rms short 2", 8'h26, rms_word(sel, 15'h0201));
    rd_chk("rms long", 8'h27, rms_word(sel, 15'h0181));
    rd_chk("pact short 2", 8'h28, 32'h0000_0003);
    rd_chk("pact long", 8'h29, 32'h0001_ffff);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_reset_values();
    t_instant();
    t_avg(1'b0);
    t_avg(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
